// file: include/hmp_pkg.sv
// Package of the host modem port register bank: addresses, indexes, field positions and resets.
// Assumes an AXI4-Lite master with 32-bit data and a codec front end feeding the stream inputs.
package hmp_pkg;

   // Printed indexed location and its byte address on the word-aligned bus.
   localparam logic [31:0] HMP_PORT_INDEX    = 32'h0C00_0022;
   localparam logic [31:0] HMP_PORT_ADDR     = {HMP_PORT_INDEX[29:0], 2'h0};
   // Index select, interrupt status and interrupt mask words.
   localparam logic [31:0] HMP_SEL_ADDR      = 32'h3000_0080;
   localparam logic [31:0] HMP_IRQ_STAT_ADDR = 32'h3000_0090;
   localparam logic [31:0] HMP_IRQ_MASK_ADDR = 32'h3000_0094;

   // Index codes of the indexed location.
   localparam logic [2:0] HMP_IDX_RX  = 3'h0;  // Read: receive word.
   localparam logic [2:0] HMP_IDX_STS = 3'h1;  // Read: status word; write: control word.
   localparam logic [2:0] HMP_IDX_ID  = 3'h2;  // Read: identity and input pins.
   localparam logic [2:0] HMP_IDX_ERR = 3'h3;  // Read: error tally; write: timeout limit.
   localparam logic [2:0] HMP_IDX_FSZ = 3'h4;  // Write: FIFO size.

   // Buffer geometry and reset values.
   localparam logic [6:0] HMP_FIFO_DEPTH = 7'h60;
   localparam logic [7:0] HMP_FSZ_RESET  = 8'h20;
   localparam logic [7:0] HMP_CTL_RESET  = 8'h00;
   localparam logic [3:0] HMP_INIT_WORDS = 4'h9;

   // Control word bit positions.
   localparam int HMP_CTL_NTORST = 7;
   localparam int HMP_CTL_ENIRQ  = 6;
   localparam int HMP_CTL_START  = 5;
   localparam int HMP_CTL_ENTX   = 3;
   // Timeout limit nibble position within the written word.
   localparam int HMP_TOC_LSB    = 8;

   // Status word bit positions.
   localparam int HMP_STS_SEL = 6;
   localparam int HMP_STS_BYTE = 5;
   localparam int HMP_STS_TO  = 4;
   localparam int HMP_STS_CFG = 3;
   localparam int HMP_STS_IRQ = 2;
   localparam int HMP_STS_OVR = 1;
   localparam int HMP_STS_UDR = 0;

   // Sticky interrupt status bit positions.
   localparam int HMP_IRQ_FULL = 0;
   localparam int HMP_IRQ_OVR  = 1;
   localparam int HMP_IRQ_UDR  = 2;
   localparam int HMP_IRQ_TO   = 3;

   // Bus responses.
   localparam logic [1:0] HMP_RESP_OKAY   = 2'h0;
   localparam logic [1:0] HMP_RESP_SLVERR = 2'h2;

   // Signals arriving from the codec side of the port.
   typedef struct packed {
      logic        rx_valid;                // One receive word offered this cycle.
      logic [15:0] rx_word;                 // The receive word.
      logic        tx_done;                 // One transmit word left the port.
      logic        tx_underrun;             // Transmit buffer ran dry.
      logic [6:0]  tx_level;                // Words held in the transmit buffer.
      logic [1:0]  frontend_select;         // Internal front-end select pair.
      logic        byte_mode_flag;          // Internal byte-mode signal.
      logic        line_current_sense_pin;  // Line-current-sense pin level.
      logic        ring_pin;                // Ring-indicator pin level.
   } hmp_codec_in_type;

endpackage : hmp_pkg

// file: src/hmp_port_regs.sv
// Register bank of the host modem port, reached over AXI4-Lite through one indexed location, an index select word and two interrupt words.
// Assumes codec inputs are synchronous to core_clk_in and the master keeps AXI4-Lite signalling.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
module hmp_port_regs #(
   parameter logic [7:0] IDENTITY_BYTE = 8'h5A  // Arbitrary value.
) (
   // Clock and reset.
   input  wire logic                      core_clk_in,
   input  wire logic                      sys_rst_in,
   // AXI4-Lite write address and data.
   input  wire logic [31:0]               s_axi_awaddr_in,
   input  wire logic                      s_axi_awvalid_in,
   output logic                           s_axi_awready_out,
   input  wire logic [31:0]               s_axi_wdata_in,
   input  wire logic [3:0]                s_axi_wstrb_in,
   input  wire logic                      s_axi_wvalid_in,
   output logic                           s_axi_wready_out,
   // AXI4-Lite write response.
   output logic [1:0]                     s_axi_bresp_out,
   output logic                           s_axi_bvalid_out,
   input  wire logic                      s_axi_bready_in,
   // AXI4-Lite read.
   input  wire logic [31:0]               s_axi_araddr_in,
   input  wire logic                      s_axi_arvalid_in,
   output logic                           s_axi_arready_out,
   output logic [31:0]                    s_axi_rdata_out,
   output logic [1:0]                     s_axi_rresp_out,
   output logic                           s_axi_rvalid_out,
   input  wire logic                      s_axi_rready_in,
   // Codec side.
   input  wire hmp_pkg::hmp_codec_in_type codec_in,
   output logic                           ptr_init_out,
   output logic                           transfer_enable_out,
   // Interrupt.
   output logic                           irq_out
);
   import hmp_pkg::*;

   // Pointer step that wraps at the physical depth.
   function automatic logic [6:0] hmp_ptr_inc(input logic [6:0] ptr);
      hmp_ptr_inc = (ptr == HMP_FIFO_DEPTH - 7'h01) ? 7'h00 : ptr + 7'h01;
   endfunction : hmp_ptr_inc

   // Byte-lane merge of a written word over an old value.
   function automatic logic [31:0] hmp_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         old_v[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
      end
      hmp_merge = old_v;
   endfunction : hmp_merge

   // Bus handshake state.
   logic        aw_held_reg;       // Write address captured.
   logic [31:0] aw_addr_reg;       // Captured write address.
   logic        w_held_reg;        // Write data captured.
   logic [31:0] w_data_reg;        // Captured write data.
   logic [3:0]  w_strb_reg;        // Captured byte strobes.
   logic        awready_reg, wready_reg, bvalid_reg;      // Write handshake outputs.
   logic        arready_reg, rvalid_reg;                  // Read handshake outputs.
   logic [1:0]  bresp_reg, rresp_reg;                     // Response codes.
   logic [31:0] rdata_reg;                                // Read data word.
   // Software-visible state.
   logic [2:0]  index_reg;         // Index select of the indexed location.
   logic [7:0]  fsz_reg;           // FIFO size field, clamped.
   logic [7:0]  ctl_reg;           // Control word low byte.
   logic [3:0]  toc_reg;           // Timeout limit nibble.
   logic [3:0]  irq_stat_reg;      // Sticky interrupt status.
   logic [3:0]  irq_mask_reg;      // Interrupt mask.
   logic        irq_reg;
   // Port status state.
   logic        to_flag_reg, cfg_done_reg;                // Timeout and init-done flags.
   logic        irq_pend_reg, ovr_flag_reg, udr_flag_reg; // Read-to-clear flags.
   logic [11:0] err_tally_reg;
   logic [11:0] tcnt_reg;          // Timeout counter.
   logic [3:0]  init_cnt_reg;      // Words sent since the start edge.
   logic        init_arm_reg;      // Counting toward init-done.
   logic        full_prev_reg;     // Buffer-full level last cycle.
   logic        ptr_init_reg;
   // Receive FIFO.
   logic [15:0] rx_mem [0:95];
   logic [6:0]  rx_wr_ptr_reg;
   logic [6:0]  rx_rd_ptr_reg;
   logic [6:0]  rx_count_reg;
   // Handshake decode.
   wire aw_take = s_axi_awvalid_in & awready_reg;
   wire w_take  = s_axi_wvalid_in & wready_reg;
   wire ar_take = s_axi_arvalid_in & arready_reg;
   wire wr_do   = aw_held_reg & w_held_reg & ~bvalid_reg;
   wire aw_held_next = (aw_held_reg | aw_take) & ~wr_do;
   wire w_held_next  = (w_held_reg | w_take) & ~wr_do;
   wire rvalid_next  = (rvalid_reg & ~s_axi_rready_in) | ar_take;
   // Write decode; port writes choose their register by the index.
   wire [31:0] wr_word   = hmp_merge(32'h0000_0000, w_data_reg, w_strb_reg);
   wire        wr_port   = wr_do & (aw_addr_reg == HMP_PORT_ADDR);
   wire        wr_sel    = wr_do & (aw_addr_reg == HMP_SEL_ADDR);
   wire        wr_stat   = wr_do & (aw_addr_reg == HMP_IRQ_STAT_ADDR);
   wire        wr_mask   = wr_do & (aw_addr_reg == HMP_IRQ_MASK_ADDR);
   wire        wr_ctl    = wr_port & (index_reg == HMP_IDX_STS);
   wire        wr_toc    = wr_port & (index_reg == HMP_IDX_ERR);
   wire        wr_fsz    = wr_port & (index_reg == HMP_IDX_FSZ);
   wire        wr_ok     = wr_sel | wr_stat | wr_mask | wr_ctl | wr_toc | wr_fsz;
   // Read decode.
   wire        rd_port   = ar_take & (s_axi_araddr_in == HMP_PORT_ADDR);
   wire        rd_rx     = rd_port & (index_reg == HMP_IDX_RX);
   wire        rd_sts    = rd_port & (index_reg == HMP_IDX_STS);
   wire        rd_id     = rd_port & (index_reg == HMP_IDX_ID);
   wire        rd_err    = rd_port & (index_reg == HMP_IDX_ERR);
   wire        rd_sel    = ar_take & (s_axi_araddr_in == HMP_SEL_ADDR);
   wire        rd_stat   = ar_take & (s_axi_araddr_in == HMP_IRQ_STAT_ADDR);
   wire        rd_mask   = ar_take & (s_axi_araddr_in == HMP_IRQ_MASK_ADDR);
   wire        rd_ok     = rd_rx | rd_sts | rd_id | rd_err | rd_sel | rd_stat | rd_mask;
   // Read words; reserved bits are tied low.
   wire [15:0] sts_word = {8'h00,
                           codec_in.frontend_select, codec_in.byte_mode_flag,
                           to_flag_reg, cfg_done_reg, irq_pend_reg, ovr_flag_reg, udr_flag_reg};
   wire [15:0] id_word  = {IDENTITY_BYTE, 6'h00,
                           codec_in.line_current_sense_pin, codec_in.ring_pin};
   wire [15:0] err_word = {4'h0, err_tally_reg};
   wire [15:0] rx_word  = rx_mem[rx_rd_ptr_reg];
   wire [31:0] rd_word  = rd_rx   ? {16'h0000, rx_word}  :
                          rd_sts  ? {16'h0000, sts_word} :
                          rd_id   ? {16'h0000, id_word}  :
                          rd_err  ? {16'h0000, err_word} :
                          rd_sel  ? {29'h0000_0000, index_reg} :
                          rd_stat ? {28'h000_0000, irq_stat_reg} :
                          rd_mask ? {28'h000_0000, irq_mask_reg} : 32'h0000_0000;

   // Receive FIFO movement; a pop on an empty FIFO just returns the stale head.
   wire rx_full   = (rx_count_reg == HMP_FIFO_DEPTH);
   wire rx_push   = codec_in.rx_valid & ~rx_full;
   wire rx_pop    = rd_rx & (rx_count_reg != 7'h00);
   wire ovr_evt   = codec_in.rx_valid & rx_full;
   wire udr_evt   = codec_in.tx_underrun;

   // Control word edges and the timeout limit.
   wire [7:0]  ctl_wr     = wr_word[7:0];
   // A locked control word ignores the start bit too, so a running link keeps its pointers.
   wire        start_rise = wr_ctl & ctl_wr[HMP_CTL_START] & ~ctl_reg[HMP_CTL_START] & ~ctl_reg[HMP_CTL_ENTX];
   wire [11:0] to_limit   = {toc_reg, 8'h00};
   wire        to_hit     = (toc_reg != 4'h0) & (tcnt_reg == to_limit);
   wire        auto_reset = to_hit & ~to_flag_reg & ~ctl_reg[HMP_CTL_NTORST];
   wire        ptr_init   = start_rise | auto_reset;

   // Buffer-full detection against the programmed size, on the rising level.
   wire        full_now = ({1'b0, rx_count_reg} >= fsz_reg) |
                          ({1'b0, codec_in.tx_level} >= fsz_reg);
   wire        full_evt = full_now & ~full_prev_reg & ctl_reg[HMP_CTL_ENIRQ];
   // A new request while one is still pending counts as unserviced.
   wire        unserviced = full_evt & irq_pend_reg;
   wire        to_evt     = to_hit & ~to_flag_reg;

   // Clamp of an oversized FIFO size write.
   wire [7:0]  fsz_wr = (wr_word[7:0] > {1'b0, HMP_FIFO_DEPTH}) ?
                        {1'b0, HMP_FIFO_DEPTH} : wr_word[7:0];
   // Error tally increment; both events in one cycle count twice.
   wire [11:0] err_inc = {11'h000, ovr_evt} + {11'h000, udr_evt};
   wire [3:0]  irq_evt = {to_evt, udr_evt, ovr_evt, full_evt};
   wire [3:0]  irq_stat_next = (irq_stat_reg & ~(wr_stat ? wr_word[3:0] : 4'h0)) | irq_evt;

   // Write channel: address and data taken in either order, one response after both.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= HMP_RESP_OKAY;
      end else begin
         aw_held_reg <= aw_held_next;
         w_held_reg  <= w_held_next;
         awready_reg <= ~aw_held_next;
         wready_reg  <= ~w_held_next;
         if (wr_do) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_ok ? HMP_RESP_OKAY : HMP_RESP_SLVERR;
         end else if (s_axi_bready_in) begin
            bvalid_reg <= 1'b0;
         end
      end
   end
   // Captured write payloads; no reset needed, they are qualified by the held flags.
   always_ff @(posedge core_clk_in) begin
      if (aw_take) begin
         aw_addr_reg <= s_axi_awaddr_in;
      end
      if (w_take) begin
         w_data_reg <= s_axi_wdata_in;
         w_strb_reg <= s_axi_wstrb_in;
      end
   end
   // Read channel: data latched at the address handshake, shown the next cycle.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= HMP_RESP_OKAY;
         rdata_reg   <= 32'h0000_0000;
      end else begin
         arready_reg <= ~rvalid_next;
         rvalid_reg  <= rvalid_next;
         if (ar_take) begin
            rdata_reg <= rd_word;
            rresp_reg <= rd_ok ? HMP_RESP_OKAY : HMP_RESP_SLVERR;
         end
      end
   end

   // Software-written registers. Once transfers are enabled the control word is frozen.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         index_reg    <= HMP_IDX_RX;
         fsz_reg      <= HMP_FSZ_RESET;
         ctl_reg      <= HMP_CTL_RESET;
         toc_reg      <= 4'h0;
         irq_mask_reg <= 4'h0;
      end else begin
         if (wr_sel) begin
            index_reg <= wr_word[2:0];
         end
         if (wr_fsz) begin
            fsz_reg <= fsz_wr;
         end
         if (wr_ctl & ~ctl_reg[HMP_CTL_ENTX]) begin
            ctl_reg <= ctl_wr;
         end
         if (wr_toc) begin
            toc_reg <= wr_word[HMP_TOC_LSB +: 4];
         end
         if (wr_mask) begin
            irq_mask_reg <= wr_word[3:0];
         end
      end
   end

   // Receive FIFO pointers and fill; a pointer reset empties it.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in | ptr_init) begin
         rx_wr_ptr_reg <= 7'h00;
         rx_rd_ptr_reg <= 7'h00;
         rx_count_reg  <= 7'h00;
      end else begin
         if (rx_push) begin
            rx_wr_ptr_reg <= hmp_ptr_inc(rx_wr_ptr_reg);
         end
         if (rx_pop) begin
            rx_rd_ptr_reg <= hmp_ptr_inc(rx_rd_ptr_reg);
         end
         rx_count_reg <= rx_count_reg + {6'h00, rx_push} - {6'h00, rx_pop};
      end
   end
   // Receive storage; plain flip-flops without reset.
   always_ff @(posedge core_clk_in) begin
      if (rx_push) begin
         rx_mem[rx_wr_ptr_reg] <= codec_in.rx_word;
      end
   end
   // Read-to-clear flags. A new event in the clearing cycle wins over the read.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         irq_pend_reg <= 1'b0;
         ovr_flag_reg <= 1'b0;
         udr_flag_reg <= 1'b0;
      end else begin
         irq_pend_reg <= full_evt | (irq_pend_reg & ~rd_sts);
         ovr_flag_reg <= ovr_evt  | (ovr_flag_reg & ~rd_sts);
         udr_flag_reg <= udr_evt  | (udr_flag_reg & ~rd_sts);
      end
   end

   // Timeout counter and flag; the counter holds at the limit and restarts on a new limit.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         tcnt_reg    <= 12'h000;
         to_flag_reg <= 1'b0;
      end else begin
         if (wr_toc) begin
            tcnt_reg <= 12'h000;
         end else if (unserviced & ~to_hit) begin
            tcnt_reg <= tcnt_reg + 12'h001;
         end
         if (to_evt) begin
            to_flag_reg <= 1'b1;
         end
      end
   end

   // Init-done tracking: armed by the start edge, set after the ninth sent word.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         init_cnt_reg <= 4'h0;
         init_arm_reg <= 1'b0;
         cfg_done_reg <= 1'b0;
      end else if (start_rise) begin
         init_cnt_reg <= 4'h0;
         init_arm_reg <= 1'b1;
         cfg_done_reg <= 1'b0;
      end else if (init_arm_reg & codec_in.tx_done) begin
         init_cnt_reg <= init_cnt_reg + 4'h1;
         if (init_cnt_reg + 4'h1 == HMP_INIT_WORDS) begin
            cfg_done_reg <= 1'b1;
            init_arm_reg <= 1'b0;
         end
      end
   end
   // Error tally and buffer-full history.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         err_tally_reg <= 12'h000;
         full_prev_reg <= 1'b0;
      end else begin
         err_tally_reg <= err_tally_reg + err_inc;
         full_prev_reg <= full_now;
      end
   end
   // Sticky interrupt status, mask gating and the pointer-reset pulse.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         irq_stat_reg <= 4'h0;
         irq_reg      <= 1'b0;
         ptr_init_reg <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_reg      <= |(irq_stat_next & irq_mask_reg);
         ptr_init_reg <= ptr_init;
      end
   end

   // Outputs, all from flip-flops.
   assign s_axi_awready_out   = awready_reg;
   assign s_axi_wready_out    = wready_reg;
   assign s_axi_bvalid_out    = bvalid_reg;
   assign s_axi_bresp_out     = bresp_reg;
   assign s_axi_arready_out   = arready_reg;
   assign s_axi_rvalid_out    = rvalid_reg;
   assign s_axi_rresp_out     = rresp_reg;
   assign s_axi_rdata_out     = rdata_reg;
   assign ptr_init_out        = ptr_init_reg;
   assign transfer_enable_out = ctl_reg[HMP_CTL_ENTX];
   assign irq_out             = irq_reg;

   // Checks of the bank's behaviour.
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);

   a_fsz_clamp_limit: assert property (fsz_reg <= {1'b0, HMP_FIFO_DEPTH})
      else $error("FIFO size above physical depth");
   a_full_sets_pending: assert property (full_evt |=> irq_pend_reg && irq_stat_reg[HMP_IRQ_FULL])
      else $error("Buffer-full event did not set pending");
   a_rx_pop_advances: assert property (rx_pop && !rx_push && !ptr_init
                                       |=> rx_count_reg == $past(rx_count_reg) - 7'h01)
      else $error("Receive read did not pop");
   a_status_read_clear: assert property (rd_sts && !full_evt && !ovr_evt && !udr_evt
                                         |=> !irq_pend_reg && !ovr_flag_reg && !udr_flag_reg)
      else $error("Status read did not clear flags");
   a_status_upper_zero: assert property (rd_sts |=> s_axi_rvalid_out && s_axi_rdata_out[15:8] == 8'h00)
      else $error("Status upper byte not zero");
   a_timeout_sets_flag: assert property (to_evt |=> to_flag_reg ##1 to_flag_reg)
      else $error("Timeout flag not set at limit");
   a_start_clears_done: assert property (start_rise |=> !cfg_done_reg && init_arm_reg && ptr_init_out)
      else $error("Start edge did not restart init");
   a_overrun_counts: assert property (ovr_evt && !udr_evt |=> err_tally_reg == $past(err_tally_reg) + 12'h001)
      else $error("Overrun not tallied");
   a_overrun_flag: assert property (ovr_evt |=> ovr_flag_reg)
      else $error("Overrun flag not set");
   a_irq_follows_mask: assert property (|(irq_stat_reg & irq_mask_reg) && !wr_stat |=> irq_out)
      else $error("Unmasked status without interrupt");
   a_write_answered: assert property (wr_do |=> s_axi_bvalid_out)
      else $error("Write not answered");

   c_status_read: cover property (rd_sts && irq_pend_reg);
   c_buffer_full: cover property (full_evt);
   c_init_done: cover property ($rose(cfg_done_reg));
   c_timeout: cover property (to_evt);

endmodule : hmp_port_regs

// file: testbench/hmp_codec_model.sv
// Codec front-end model that feeds the stream and pin inputs of the modem port.
// Assumes callers enter its task right after a rising edge of clk_in.
`timescale 1ns/10ps
module hmp_codec_model (
   // Clock.
   input  wire logic                 clk_in,
   // Codec signals toward the port.
   output hmp_pkg::hmp_codec_in_type codec_out
);
   import hmp_pkg::*;
   // Pins at fixed levels, so every status and identity read has a known low byte.
   initial codec_out = '{rx_valid: 1'b0, rx_word: 16'h0000, tx_done: 1'b0, tx_underrun: 1'b0,
      tx_level: 7'h00, frontend_select: 2'h2, byte_mode_flag: 1'b1, line_current_sense_pin: 1'b1, ring_pin: 1'b0};
   // One event pulse {receive, transmit done, underrun}; the word is inverted afterwards so a stale read shows.
   task automatic send(input logic [2:0] ev, input logic [15:0] w);
      {codec_out.rx_valid, codec_out.tx_done, codec_out.tx_underrun} <= ev;
      codec_out.rx_word <= w;
      @(posedge clk_in);
      {codec_out.rx_valid, codec_out.tx_done, codec_out.tx_underrun} <= 3'h0;
      codec_out.rx_word <= ~w;
      @(posedge clk_in);
   endtask : send
   // Transmit fill pulses: the level stands for one cycle, then the buffer reads empty for one, n times over.
   task automatic fill(input int n, input logic [6:0] lv);
      repeat (n) begin
         codec_out.tx_level <= lv;
         @(posedge clk_in);
         codec_out.tx_level <= 7'h00;
         @(posedge clk_in);
      end
   endtask : fill
endmodule : hmp_codec_model

// file: testbench/hmp_port_regs_bench.sv
// Self-checking bench of the modem port register bank over AXI4-Lite.
// Assumes hmp_codec_model drives the codec inputs; identity byte value is arbitrary.
`timescale 1ns/10ps
module hmp_port_regs_bench;
   import hmp_pkg::*;
   logic             clk, rst, aw_v, w_v, b_r, ar_v, r_r, aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq, p_init, t_en;
   logic [31:0]      aw_a, w_d, ar_a, r_d, d;
   logic [1:0]       b_resp, r_resp, r;
   hmp_codec_in_type codec;
   int               num_errors = 0;
   int               samples_checked = 0;
   int               n_init = 0;
   hmp_codec_model u_codec (.clk_in(clk), .codec_out(codec));
   hmp_port_regs #(.IDENTITY_BYTE(8'h3C)) u_dut (.core_clk_in(clk), .sys_rst_in(rst), .s_axi_awaddr_in(aw_a),
      .s_axi_awvalid_in(aw_v), .s_axi_awready_out(aw_rdy), .s_axi_wdata_in(w_d), .s_axi_wstrb_in(4'hF),
      .s_axi_wvalid_in(w_v), .s_axi_wready_out(w_rdy), .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_v),
      .s_axi_bready_in(b_r), .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v), .s_axi_arready_out(ar_rdy),
      .s_axi_rdata_out(r_d), .s_axi_rresp_out(r_resp), .s_axi_rvalid_out(r_v), .s_axi_rready_in(r_r),
      .codec_in(codec), .ptr_init_out(p_init), .transfer_enable_out(t_en), .irq_out(irq));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Pointer-reset pulses from the port, counted by non-blocking update so a check at the edge sees a settled count.
   always @(posedge clk) begin
      if (p_init) n_init <= n_init + 1;
   end
   task automatic finish_test;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // A wait that never ends is a failure in its own right.
   task automatic hang;
      num_errors++;
      finish_test();
   endtask : hang
   // Write: address and data offered together, each released when taken, one spare edge after.
   task automatic bw(input logic [31:0] a, input logic [31:0] v, output logic [1:0] e);
      int n = 0;
      aw_a <= a;
      w_d  <= v;
      aw_v <= 1'b1;
      w_v  <= 1'b1;
      b_r  <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (aw_rdy) aw_v <= 1'b0;
         if (w_rdy) w_v <= 1'b0;
      end while (!b_v && n < 99);
      if (!b_v) hang();
      e = b_resp;
      b_r <= 1'b0;
      @(posedge clk);
   endtask : bw
   task automatic br(input logic [31:0] a, output logic [31:0] q, output logic [1:0] e);
      int n = 0;
      ar_a <= a;
      ar_v <= 1'b1;
      r_r  <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (ar_rdy) ar_v <= 1'b0;
      end while (!r_v && n < 99);
      if (!r_v) hang();
      q = r_d;
      e = r_resp;
      r_r <= 1'b0;
      @(posedge clk);
   endtask : br
   // Select an index, then read the indexed location and compare.
   task automatic rdc(input logic [2:0] i, input logic [31:0] exp);
      bw(HMP_SEL_ADDR, {29'h0, i}, r);
      br(HMP_PORT_ADDR, d, r);
      chk(d, exp);
   endtask : rdc
   task automatic s_idle;
      rdc(HMP_IDX_ID, 32'h0000_3C02);
      rdc(HMP_IDX_STS, 32'h0000_00A0);
      rdc(HMP_IDX_ERR, 32'h0000_0000);
      bw(32'h3000_0100, 32'h0000_0001, r);
      chk({30'h0, r}, {30'h0, HMP_RESP_SLVERR});
      br(32'h3000_0100, d, r);
      chk({r, d[29:0]}, {HMP_RESP_SLVERR, 30'h0});
   endtask : s_idle
   task automatic s_rx;
      u_codec.send(3'h4, 16'h1234);
      u_codec.send(3'h4, 16'hBEEF);
      rdc(HMP_IDX_RX, 32'h0000_1234);
      rdc(HMP_IDX_RX, 32'h0000_BEEF);
   endtask : s_rx
   // One word beyond the 96-word depth overruns, then one underrun; reads clear both.
   task automatic s_err;
      repeat (97) u_codec.send(3'h4, 16'h5555);
      rdc(HMP_IDX_STS, 32'h0000_00A2);
      u_codec.send(3'h1, 16'h0000);
      rdc(HMP_IDX_STS, 32'h0000_00A1);
      rdc(HMP_IDX_STS, 32'h0000_00A0);
      rdc(HMP_IDX_ERR, 32'h0000_0002);
   endtask : s_err
   // Pointer init with the buffer still full; a size of two words then trips the full interrupt.
   task automatic s_init;
      bw(HMP_SEL_ADDR, {29'h0, HMP_IDX_FSZ}, r);
      bw(HMP_PORT_ADDR, 32'h0000_0002, r);
      bw(HMP_SEL_ADDR, {29'h0, HMP_IDX_STS}, r);
      bw(HMP_PORT_ADDR, 32'h0000_0060, r);
      br(HMP_PORT_ADDR, d, r);
      bw(HMP_IRQ_STAT_ADDR, 32'h0000_000F, r);
      repeat (8) u_codec.send(3'h2, 16'h0000);
      rdc(HMP_IDX_STS, 32'h0000_00A0);
      u_codec.send(3'h2, 16'h0000);
      u_codec.send(3'h4, 16'h1234);
      u_codec.send(3'h4, 16'h0042);
      rdc(HMP_IDX_STS, 32'h0000_00AC);
      rdc(HMP_IDX_RX, 32'h0000_1234);
      br(HMP_IRQ_STAT_ADDR, d, r);
      chk(d, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0);
      bw(HMP_IRQ_MASK_ADDR, 32'h0000_0001, r);
      chk({31'h0, irq}, 32'h1);
      bw(HMP_IRQ_STAT_ADDR, 32'h0000_0001, r);
      chk({31'h0, irq}, 32'h0);
   endtask : s_init
   // Fill pulses while the request stays pending; the 256th unserviced one meets the limit 0x100.
   task automatic s_tmo;
      bw(HMP_SEL_ADDR, {29'h0, HMP_IDX_ERR}, r);
      bw(HMP_PORT_ADDR, 32'h0000_0100, r);
      u_codec.fill(256, 7'h02);
      br(HMP_IRQ_STAT_ADDR, d, r);
      chk(d, 32'h0000_0001);
      u_codec.fill(1, 7'h02);
      br(HMP_IRQ_STAT_ADDR, d, r);
      chk(d, 32'h0000_0009);
      rdc(HMP_IDX_STS, 32'h0000_00BC);
      chk(n_init, 2);
      bw(HMP_PORT_ADDR, 32'h0000_0048, r);
      bw(HMP_PORT_ADDR, 32'h0000_0020, r);
      chk({31'h0, t_en}, 32'h1);
      chk(n_init, 2);
   endtask : s_tmo
   initial begin
      rst = 1'b1;
      {aw_v, w_v, b_r, ar_v, r_r} = 5'h00;
      {aw_a, w_d, ar_a} = 96'h0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      s_idle();
      s_rx();
      s_err();
      s_init();
      s_tmo();
      finish_test();
   end
endmodule : hmp_port_regs_bench
